// ---- hw/sipm_stop_reset.sv ----
/*
  Stop-mode sequencer, reset-source status and break flag-clear control.
  Assumes a synchronous processor bus on clk, a crystal-clock tick input
  and reset-cause strobes that are valid in the cycle reset is asserted.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipm_cfg.svh"
module sipm_stop_reset (
  input wire logic clk,
  input wire logic reset,
  input wire logic porCause,
  input wire logic pinCause,
  input wire logic watchdogCause,
  input wire logic illegalOpcodeCause,
  input wire logic illegalAddrFetchCause,
  input wire logic lowVoltageCause,
  input wire logic stopExec,
  input wire logic interruptReq,
  input wire logic breakReq,
  input wire logic crystalTick,
  input wire logic shortRecoverySelect,
  input wire logic [15:0] busAddr,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata,
  output logic baseClockEnable,
  output logic crystalClockEnable,
  output logic cpuRelease,
  output logic breakClearAllowed,
  output logic breakExitedLowpowerFlag
);
  import sipm_pkg::*;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  sipm_state_e state_reg;
  sipm_state_e state_next;
  sipm_count_t count_reg;
  logic wokeByBreak_reg;
  logic [7:0] resetSource_reg;
  logic breakClearEnable_reg;
  logic [7:0] rdata_next;
  wire logic selBreak = busAddr == `SIPM_ADDR_BREAK_EXIT_STATUS;
  wire logic selReset = busAddr == `SIPM_ADDR_RESET_SOURCE_STATUS;
  wire logic selCtrl = busAddr == `SIPM_ADDR_BREAK_FLAG_CLEAR_CONTROL;
  wire logic readReset = busRead && selReset;
  wire logic writeBreak = busWrite && selBreak;
  wire logic clearBreakFlag =
    writeBreak && !busWdata[`SIPM_BIT_BREAK_EXITED]; // RULE9
  wire logic wake = interruptReq || breakReq; // RULE2 RULE3
  wire sipm_count_t target = shortRecoverySelect ?
    `SIPM_RECOVERY_SHORT : `SIPM_RECOVERY_LONG; // RULE5
  wire logic countDone = count_reg == target;
  wire logic breakWake = state_reg == SIPM_STOPPED && breakReq;

  always_comb begin
    rdata_next = 8'h00;
    if (busRead && selBreak) begin
      rdata_next[`SIPM_BIT_BREAK_EXITED] = breakExitedLowpowerFlag;
    end
    if (readReset) begin
      rdata_next = resetSource_reg;
    end
    if (busRead && selCtrl) begin
      rdata_next[`SIPM_BIT_BREAK_CLEAR_ENABLE] = breakClearEnable_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Stop sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SIPM_RUN: begin
        if (stopExec) begin
          state_next = SIPM_STOPPED; // RULE1
        end
      end
      SIPM_STOPPED: begin
        if (wake) begin
          state_next = SIPM_RECOVER; // RULE8
        end
      end
      SIPM_RECOVER: begin
        if (countDone) begin
          state_next = SIPM_RELEASE; // RULE20
        end
      end
      SIPM_RELEASE: state_next = SIPM_RUN;
      default: state_next = SIPM_RUN;
    endcase
  end

  // Reset itself ends stop, since the sequencer returns to run.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SIPM_RUN; // RULE3
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg != SIPM_RECOVER) begin
        count_reg <= '0; // RULE1 RULE8
      end else if (crystalTick && !countDone) begin
        count_reg <= count_reg + 13'h0001; // RULE8
      end
    end
  end

  // Clocks come back one cycle ahead of release so the core sees a live
  // clock before it starts stacking.
  always_ff @(posedge clk) begin
    if (reset) begin
      baseClockEnable <= 1'b1;
      crystalClockEnable <= 1'b1;
      cpuRelease <= 1'b0;
    end else begin
      baseClockEnable <= state_next == SIPM_RUN ||
        state_next == SIPM_RELEASE; // RULE4 RULE20
      crystalClockEnable <= state_next == SIPM_RUN ||
        state_next == SIPM_RELEASE; // RULE4
      cpuRelease <= state_reg == SIPM_RELEASE; // RULE2 RULE20
    end
  end

  // ----------------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wokeByBreak_reg <= 1'b0;
      breakExitedLowpowerFlag <= 1'b0; // RULE9
    end else begin
      if (breakWake) begin
        wokeByBreak_reg <= 1'b1;
      end else if (state_reg == SIPM_RUN) begin
        wokeByBreak_reg <= 1'b0;
      end
      if (state_reg == SIPM_RELEASE && wokeByBreak_reg) begin
        breakExitedLowpowerFlag <= 1'b1; // RULE7
      end else if (clearBreakFlag) begin
        breakExitedLowpowerFlag <= 1'b0; // RULE9
      end
    end
  end

  // The cause strobes are sampled while reset is held, so the source
  // survives the reset that it caused.
  always_ff @(posedge clk) begin
    if (reset && porCause) begin
      resetSource_reg <= `SIPM_RESET_SOURCE_POR; // RULE11
    end else if (reset) begin
      if (pinCause) begin
        resetSource_reg[`SIPM_BIT_PIN] <= 1'b1; // RULE12
      end
      if (watchdogCause) begin
        resetSource_reg[`SIPM_BIT_WATCHDOG] <= 1'b1; // RULE13
      end
      if (illegalOpcodeCause) begin
        resetSource_reg[`SIPM_BIT_ILLEGAL_OPCODE] <= 1'b1; // RULE14
      end
      if (illegalAddrFetchCause) begin
        resetSource_reg[`SIPM_BIT_ILLEGAL_ADDRESS] <= 1'b1; // RULE15
      end
      if (lowVoltageCause) begin
        resetSource_reg[`SIPM_BIT_LOW_VOLTAGE] <= 1'b1; // RULE16
      end
    end else if (readReset) begin
      resetSource_reg <= 8'h00; // RULE10
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      breakClearEnable_reg <= 1'b0;
      breakClearAllowed <= 1'b0;
      busRdata <= 8'h00;
    end else begin
      if (busWrite && selCtrl) begin
        breakClearEnable_reg <= busWdata[`SIPM_BIT_BREAK_CLEAR_ENABLE];
      end
      // Peripherals gate their own clears with this level; a cleared
      // flag is not restored, and a second step in break is refused.
      breakClearAllowed <= busWrite && selCtrl ?
        busWdata[`SIPM_BIT_BREAK_CLEAR_ENABLE] :
        breakClearEnable_reg; // RULE17 RULE18 RULE19
      busRdata <= rdata_next;
    end
  end
endmodule // sipm_stop_reset
`default_nettype wire

// ---- hw/sipm_cfg.svh ----
/*
  Constants for the stop-mode and reset-status block of the system
  integration unit: register addresses, bit positions and recovery counts.
  Assumes inclusion by bare name from the design module.
*/
// Functional notes
// (RULE1) Stop entry resets counter, disables clocks.
// (RULE2) Enabled interrupt exits stop after recovery.
// (RULE3) Reset or break also ends stop.
// (RULE4) Base and crystal clocks held off in stop.
// (RULE5) Recovery is 4096 cycles, or 32 if short.
// (RULE6) Crystal systems should keep short recovery clear.
// (RULE7) Break exit sets break-exited-low-power flag.
// (RULE8) Counter held until recovery, then counts.
// (RULE9) Write zero or reset clears break flag.
// (RULE10) Reading reset status clears all six flags.
// (RULE11) Power-on sets its flag, clears others.
// (RULE12) Pin reset sets external-pin flag.
// (RULE13) Watchdog reset sets watchdog flag.
// (RULE14) Illegal opcode reset sets its flag.
// (RULE15) Only illegal opcode fetch sets address flag.
// (RULE16) Low-voltage reset sets its flag.
// (RULE17) Break-time flag clears need clear-enable set.
// (RULE18) Flag cleared in break stays cleared.
// (RULE19) Pre-break first step cannot clear in break.
// (RULE20) At count, enable clocks, then release processor.
`ifndef SIPM_CFG_SVH
`define SIPM_CFG_SVH
`define SIPM_ADDR_BREAK_EXIT_STATUS 16'hfe00
`define SIPM_ADDR_RESET_SOURCE_STATUS 16'hfe01
`define SIPM_ADDR_BREAK_FLAG_CLEAR_CONTROL 16'hfe03
`define SIPM_BIT_BREAK_EXITED 1
`define SIPM_BIT_BREAK_CLEAR_ENABLE 7
`define SIPM_BIT_POR 7
`define SIPM_BIT_PIN 6
`define SIPM_BIT_WATCHDOG 5
`define SIPM_BIT_ILLEGAL_OPCODE 4
`define SIPM_BIT_ILLEGAL_ADDRESS 3
`define SIPM_BIT_LOW_VOLTAGE 1
`define SIPM_RECOVERY_LONG 13'h1000
`define SIPM_RECOVERY_SHORT 13'h0020
`define SIPM_RESET_SOURCE_POR 8'h80
`endif

// ---- hw/sipm_pkg.sv ----
/*
  Types for the stop-mode and reset-status block.
  Assumes the constants header is on the include path.
*/
package sipm_pkg;
  typedef enum logic [1:0] {
    SIPM_RUN,
    SIPM_STOPPED,
    SIPM_RECOVER,
    SIPM_RELEASE
  } sipm_state_e;
  typedef logic [12:0] sipm_count_t;
endpackage

// ---- dv/sipm_core_model.sv ----
/* Stand-in for the oscillator and core: free crystal ticks, release count.
   Assumes the bench drives clk and reset. */
`timescale 1ns/1ps
`default_nettype none
module sipm_core_model (
  input wire logic clk, reset, clocksOn, cpuRelease,
  output logic crystalTick,
  output logic [7:0] releases
);
  // The oscillator keeps ticking in stop so that recovery can be timed.
  always_ff @(posedge clk) begin
    crystalTick <= reset ? 1'b0 : !crystalTick;
    releases <= reset ? 8'h00 : releases + {7'h0, cpuRelease & clocksOn};
  end
endmodule // sipm_core_model
`default_nettype wire

// ---- dv/sipm_stop_reset_properties.sv ----
/* Checker of the stop sequencer and status registers.
   Assumes binding to sipm_stop_reset; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module sipm_stop_reset_properties (
  input wire logic clk, reset, stopExec, breakReq, crystalTick,
  input wire logic shortRecoverySelect, busRead, busWrite,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busWdata, busRdata,
  input wire logic baseClockEnable, crystalClockEnable, cpuRelease,
  input wire logic breakClearAllowed, breakExitedLowpowerFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [12:0] offTicks;
  // Counts every tick while gated, so it can only overstate the wait.
  always_ff @(posedge clk)
    if (reset || baseClockEnable) offTicks <= 13'h0;
    else if (crystalTick && !(&offTicks)) offTicks <= offTicks + 13'h1;
  sequence srcRead; busRead && busAddr == 16'hfe01; endsequence
  sequence stopTaken; stopExec && baseClockEnable && !cpuRelease; endsequence
  AST_STOP_GATES: assert property (stopTaken |=> !baseClockEnable)
    else $error("clocks still on after stop");
  AST_GATES_TIED: assert property (baseClockEnable == crystalClockEnable)
    else $error("clock enables differ");
  AST_HELD_OFF: assert property ($fell(baseClockEnable) |-> !baseClockEnable[*8])
    else $error("clocks back too soon");
  AST_SHORT_MIN: assert property ($rose(baseClockEnable) |-> offTicks >= 13'd32)
    else $error("recovery shorter than 32 ticks");
  AST_LONG_MIN: assert property ($rose(baseClockEnable) && !shortRecoverySelect
    |-> offTicks >= 13'd4096) else $error("recovery shorter than 4096 ticks");
  AST_RELEASE_ORDER: assert property ($rose(cpuRelease) |-> $past(baseClockEnable))
    else $error("release before clocks");
  AST_RELEASE_PULSE: assert property (cpuRelease |=> !cpuRelease)
    else $error("release longer than one cycle");
  AST_BREAK_SETS: assert property ($rose(cpuRelease) && breakReq |-> ##[0:1] breakExitedLowpowerFlag)
    else $error("break exit flag not set");
  AST_FLAG_WR0: assert property (busWrite && busAddr == 16'hfe00 && !busWdata[1] && baseClockEnable && !cpuRelease
    |=> !breakExitedLowpowerFlag) else $error("flag not cleared by write");
  AST_FLAG_RESET: assert property (@(posedge clk) disable iff (1'b0) reset |=> !breakExitedLowpowerFlag)
    else $error("flag survives reset");
  AST_READ_CLEARS: assert property (srcRead ##1 srcRead |=> busRdata == 8'h00)
    else $error("reset flags not cleared by read");
  AST_CLEAR_ENABLE: assert property (busWrite && busAddr == 16'hfe03 |=> breakClearAllowed == $past(busWdata[7]))
    else $error("clear enable not written");
endmodule // sipm_stop_reset_properties
bind sipm_stop_reset sipm_stop_reset_properties i_props (.clk, .reset, .stopExec, .breakReq, .crystalTick,
  .shortRecoverySelect, .busRead, .busWrite, .busAddr, .busWdata, .busRdata, .baseClockEnable,
  .crystalClockEnable, .cpuRelease, .breakClearAllowed, .breakExitedLowpowerFlag);
`default_nettype wire

// ---- dv/sipm_stop_reset_tb.sv ----
/* Self-checking bench of the stop sequencer and status registers.
   Assumes the core model supplies ticks every second clock. */
`timescale 1ns/1ps
`default_nettype none
module sipm_stop_reset_tb;
  logic clk = 0, reset = 1, stopExec = 0, interruptReq = 0, breakReq = 0;
  logic shortRecoverySelect = 0, busRead = 0, busWrite = 0, crystalTick;
  logic baseClockEnable, crystalClockEnable, cpuRelease, breakClearAllowed, breakExitedLowpowerFlag;
  logic [5:0] cause = 6'h20;
  logic [15:0] busAddr = 16'h0;
  logic [7:0] busWdata = 8'h0, busRdata, releases;
  logic [31:0] seed = 38549;
  int mismatches = 0, checked = 0, cycles = 0, n, w;
  always #12.5 clk = !clk;
  sipm_stop_reset i_dut (.clk, .reset, .porCause(cause[5]), .pinCause(cause[4]),
    .watchdogCause(cause[3]), .illegalOpcodeCause(cause[2]), .illegalAddrFetchCause(cause[1]),
    .lowVoltageCause(cause[0]), .stopExec, .interruptReq, .breakReq, .crystalTick,
    .shortRecoverySelect, .busAddr, .busRead, .busWrite, .busWdata, .busRdata, .baseClockEnable,
    .crystalClockEnable, .cpuRelease, .breakClearAllowed, .breakExitedLowpowerFlag);
  sipm_core_model i_core (.clk, .reset, .clocksOn(baseClockEnable), .cpuRelease, .crystalTick, .releases);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] srcFlags(logic [5:0] c);
    return c[5] ? 8'h80 : {1'b0, c[4:1], 1'b0, c[0], 1'b0};
  endfunction
  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobes are left high so that accesses can run back to back.
  task automatic bus(logic r, logic [15:0] a, logic [7:0] d);
    busRead = r;
    busWrite = !r;
    busAddr = a;
    busWdata = d;
    @(negedge clk);
  endtask
  task automatic rdChk(logic [15:0] a, logic [7:0] exp);
    bus(1'b1, a, 8'h00);
    cmp(busRdata, exp);
  endtask
  task automatic idle;
    busRead = 0;
    busWrite = 0;
    @(negedge clk);
  endtask
  task automatic doReset(logic [5:0] c);
    cause = c;
    reset = 1;
    repeat (4) @(negedge clk);
    reset = 0;
    cause = 0;
  endtask
  task automatic stop_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    for (n = 0; n < 8; n++) begin
      seed = xs(seed);
      doReset(n == 0 ? 6'h20 : n == 1 ? 6'h1f : seed[5:0]);
      rdChk(16'hfe01, srcFlags(n == 0 ? 6'h20 : n == 1 ? 6'h1f : seed[5:0]));
      rdChk(16'hfe01, 8'h00);
      bus(1'b0, 16'hfe03, {seed[7], 7'h0});
      bus(1'b0, 16'hfe02, 8'hff);
      rdChk(16'hfe03, {seed[7], 7'h0});
      cmp({7'h0, breakClearAllowed}, {7'h0, seed[7]});
      rdChk(16'hfe02, 8'h00);
      rdChk(16'hfe00, 8'h00);
      idle();
      $display("reset test %0d done", n);
    end
    for (n = 0; n < 4; n++) begin
      shortRecoverySelect = n[0];
      stopExec = 1;
      @(negedge clk);
      stopExec = 0;
      repeat (3) @(negedge clk);
      cmp({6'h0, baseClockEnable, crystalClockEnable}, 8'h00);
      if (n[1]) breakReq = 1;
      else interruptReq = 1;
      for (w = 0; w < 9000 && cpuRelease !== 1'b1; w++) @(negedge clk);
      cmp({7'h0, w >= (n[0] ? 62 : 8190) && w <= (n[0] ? 80 : 8208)}, 8'h01);
      interruptReq = 0;
      breakReq = 0;
      rdChk(16'hfe00, {6'h0, n[1], 1'b0});
      bus(1'b0, 16'hfe00, 8'h00);
      rdChk(16'hfe00, 8'h00);
      idle();
      $display("stop test %0d done", n);
    end
    cmp(releases, 8'h04);
    stopExec = 1;
    @(negedge clk);
    stopExec = 0;
    repeat (3) @(negedge clk);
    doReset(6'h10);
    cmp({7'h0, baseClockEnable}, 8'h01);
    rdChk(16'hfe01, srcFlags(6'h10));
    idle();
    $display("reset exit test done");
    stop_test();
  end
endmodule // sipm_stop_reset_tb
`default_nettype wire
